/* src/pcdc_top.v */
`timescale 1ns/10ps
`include "pcdc_map.vh"
module pcdc_top #(
    parameter DIV_W = 5
) (
    input wire clk,
    input wire arst_n,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output wire [31:0] avs_readdata_w,
    output wire avs_waitrequest,
    input wire [2:0] power_mode,
    input wire [3:0] standby_settle_time,
    output reg [1:0] mult_active,
    output reg [2:0] div_active,
    output reg settling,
    output reg sysclk_en,
    output reg clkout_o,
    output reg clkout_oe,
    output reg run_enable
);
    // Registers answer in one cycle: waitrequest high on the first cycle of a request
    // Writes land on the edge that ends the wait, as the master expects
    reg ack;
    reg [31:0] rdata;
    reg [7:0] sys_clk_ctrl;
    reg [7:0] pll_mult_ctrl;
    reg [2:0] mode_s1;
    reg [2:0] mode_s2;
    reg [3:0] sts_s1;
    reg [3:0] sts_s2;
    reg pending;
    reg [2:0] prev_mode;
    reg [11:0] settle_cnt;
    reg [DIV_W-1:0] div_cnt;
    reg [DIV_W-1:0] next_div_cnt;
    reg [31:0] next_rdata;
    wire req = avs_read | avs_write;
    wire wr = avs_write & ack & avs_byteenable[0];
    wire in_swstby = (mode_s2 == `PCDC_MODE_SWSTBY);
    wire in_hwstby = (mode_s2 == `PCDC_MODE_HWSTBY);
    wire [1:0] mult_sel = pll_mult_ctrl[`PCDC_PMC_MULT_LO+1:`PCDC_PMC_MULT_LO];
    wire [2:0] div_sel = sys_clk_ctrl[`PCDC_SCC_DIV_LO+2:`PCDC_SCC_DIV_LO];

    function [DIV_W-1:0] pcdc_div_mask;
        input [2:0] sel;
        begin
            case (sel)
                3'h0: pcdc_div_mask = 5'h00;
                3'h1: pcdc_div_mask = 5'h01;
                3'h2: pcdc_div_mask = 5'h03;
                3'h3: pcdc_div_mask = 5'h07;
                3'h4: pcdc_div_mask = 5'h0f;
                3'h5: pcdc_div_mask = 5'h1f;
                default: pcdc_div_mask = 5'h1f;
            endcase
        end
    endfunction

    assign avs_waitrequest = req & ~ack;
    assign avs_readdata_w = rdata;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_s1 <= 3'h0;
            mode_s2 <= 3'h0;
            sts_s1 <= 4'h0;
            sts_s2 <= 4'h0;
        end else begin
            mode_s1 <= power_mode;
            mode_s2 <= mode_s1;
            sts_s1 <= standby_settle_time;
            sts_s2 <= sts_s1;
        end
    end

    always @* begin
        next_rdata = 32'h0000_0000;
        case (avs_address)
            `PCDC_ADDR_SYS_CLK_CTRL: next_rdata = {24'h0, sys_clk_ctrl & `PCDC_SCC_WMASK};
            `PCDC_ADDR_PLL_MULT_CTRL: next_rdata = {24'h0, pll_mult_ctrl & `PCDC_PMC_WMASK};
            `PCDC_ADDR_STATUS: next_rdata = {25'h0, pending, settling, div_active, mult_active};
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ack <= 1'b0;
            rdata <= 32'h0000_0000;
            sys_clk_ctrl <= `PCDC_SCC_RESET;
            pll_mult_ctrl <= `PCDC_PMC_RESET;
        end else begin
            ack <= req & ~ack;
            if (avs_read & ~ack)
                rdata <= next_rdata;
            if (wr && avs_address == `PCDC_ADDR_SYS_CLK_CTRL)
                sys_clk_ctrl <= avs_writedata[7:0] & `PCDC_SCC_WMASK;
            if (wr && avs_address == `PCDC_ADDR_PLL_MULT_CTRL)
                pll_mult_ctrl <= avs_writedata[7:0] & `PCDC_PMC_WMASK;
        end
    end

    // Multiplier in effect and settle sequencing
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mult_active <= 2'h0;
            pending <= 1'b0;
            prev_mode <= 3'h0;
            settle_cnt <= 12'h000;
            settling <= 1'b0;
        end else begin
            prev_mode <= mode_s2;
            if (sys_clk_ctrl[`PCDC_SCC_SWITCH_MODE]) begin
                mult_active <= mult_sel;
                pending <= 1'b0;
            end else if (mult_sel != mult_active) begin
                pending <= 1'b1;
            end
            if (in_swstby && pending && !sys_clk_ctrl[`PCDC_SCC_SWITCH_MODE]) begin
                mult_active <= mult_sel;
                pending <= 1'b0;
                settle_cnt <= {4'h0, sts_s2 * `PCDC_SETTLE_UNIT};
            end
            if (prev_mode == `PCDC_MODE_SWSTBY && !in_swstby && settle_cnt != 12'h000)
                settling <= 1'b1;
            if (settling) begin
                if (settle_cnt == 12'h001)
                    settling <= 1'b0;
                settle_cnt <= settle_cnt - 12'h001;
            end
        end
    end

    // Divider; ratio only changes on a wrap so no runt pulse occurs
    always @* begin
        next_div_cnt = div_cnt + 5'h01;
        if ((div_cnt & pcdc_div_mask(div_active)) == pcdc_div_mask(div_active))
            next_div_cnt = 5'h00;
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_cnt <= 5'h00;
            div_active <= 3'h0;
            sysclk_en <= 1'b0;
            run_enable <= 1'b0;
        end else begin
            div_cnt <= next_div_cnt;
            if (next_div_cnt == 5'h00)
                div_active <= div_sel;
            // Rising edge of the enable lines up with the reference edge
            sysclk_en <= (next_div_cnt == 5'h00) & ~in_swstby & ~in_hwstby;
            run_enable <= ~in_swstby & ~in_hwstby & ~settling;
        end
    end

    // Clock-out pin
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            clkout_o <= 1'b1;
            clkout_oe <= 1'b0;
        end else begin
            clkout_oe <= ~in_hwstby;
            if (in_swstby || in_hwstby || sys_clk_ctrl[`PCDC_SCC_CLKOUT_DIS])
                clkout_o <= 1'b1;
            else
                clkout_o <= (div_cnt <= (pcdc_div_mask(div_active) >> 1));
        end
    end
endmodule

/* src/pcdc_map.vh */
`ifndef PCDC_MAP_VH
`define PCDC_MAP_VH
`define PCDC_ADDR_SYS_CLK_CTRL 4'h0
`define PCDC_ADDR_PLL_MULT_CTRL 4'h4
`define PCDC_ADDR_MODE_CTRL 4'h8
`define PCDC_ADDR_STATUS 4'hc
`define PCDC_SCC_CLKOUT_DIS 7
`define PCDC_SCC_RSV6 6
`define PCDC_SCC_SWITCH_MODE 3
`define PCDC_SCC_DIV_LO 0
`define PCDC_PMC_RSV3 3
`define PCDC_PMC_MULT_LO 0
`define PCDC_SCC_RESET 8'h00
`define PCDC_PMC_RESET 8'h00
`define PCDC_SCC_WMASK 8'hcf
`define PCDC_PMC_WMASK 8'h0b
`define PCDC_MODE_NORMAL 3'h0
`define PCDC_MODE_SLEEP 3'h1
`define PCDC_MODE_ALLSTOP 3'h2
`define PCDC_MODE_SWSTBY 3'h3
`define PCDC_MODE_HWSTBY 3'h4
`define PCDC_SETTLE_UNIT 8'h10
`endif

/* tb/pcdc_checker.sv */
`timescale 1ns/10ps
module pcdc_checker (
    input wire clk,
    input wire arst_n,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_readdata_w,
    input wire avs_waitrequest,
    input wire [2:0] power_mode,
    input wire [1:0] mult_active,
    input wire [2:0] div_active,
    input wire settling,
    input wire clkout_o,
    input wire clkout_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence one_wait_s; avs_waitrequest ##1 !avs_waitrequest; endsequence
    sequence rd_done_s; avs_read && !avs_waitrequest; endsequence
    one_wait_a: assert property ($rose(avs_read || avs_write) |-> one_wait_s) else $error("bad wait");
    unmapped_zero_a: assert property (rd_done_s and avs_address == 4'h8 |-> avs_readdata_w == 32'h0) else $error("unmapped read");
    scc_rsv_a: assert property (rd_done_s and avs_address == 4'h0 |-> avs_readdata_w[5:4] == 2'h0) else $error("scc reserved");
    pmc_rsv_a: assert property (rd_done_s and avs_address == 4'h4 |-> avs_readdata_w[7:4] == 4'h0 && !avs_readdata_w[2]) else $error("pmc reserved");
    hw_stby_hiz_a: assert property ((power_mode == 3'h4) [*5] |-> !clkout_oe) else $error("hw standby drive");
    sw_stby_high_a: assert property ((power_mode == 3'h3) [*5] |-> clkout_o) else $error("sw standby low");
    mult_legal_a: assert property (mult_active != 2'h3) else $error("mult code");
    div_legal_a: assert property (div_active <= 3'h5) else $error("div code");
    settle_hold_a: assert property (settling && $past(settling) |-> $stable(mult_active)) else $error("mult moved");
endmodule
bind pcdc_top pcdc_checker chk_i (.*);

/* tb/pcdc_osc_model.sv */
`timescale 1ns/10ps
module pcdc_osc_model (
    input wire [2:0] power_mode,
    output logic osc_out_pin
);
    logic ph = 1'b0;
    always #20 ph = ~ph;
    // Held high in either standby so the generator restarts cleanly
    assign osc_out_pin = (power_mode >= 3'h3) ? 1'b1 : ph;
endmodule

/* tb/testbench.sv */
`timescale 1ns/10ps
module testbench;
    logic clk = 0, arst_n = 0, avs_read = 0, avs_write = 0, settling, sysclk_en, clkout_o;
    logic [3:0] avs_address = 0, sst = 4'h2;
    logic [31:0] avs_writedata = 0, avs_readdata_w;
    logic avs_waitrequest, clkout_oe, run_enable, osc;
    logic [2:0] power_mode = 0, div_active;
    logic [1:0] mult_active;
    logic [7:0] q;
    logic [19:0] rows [5];
    int fail_count = 0, tests_run = 0, cyc = 0, n, i, m;
    always #20 clk = ~clk;
    pcdc_top DUT (.clk(clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata_w(avs_readdata_w), .avs_waitrequest(avs_waitrequest),
        .power_mode(power_mode), .standby_settle_time(sst), .mult_active(mult_active),
        .div_active(div_active), .settling(settling), .sysclk_en(sysclk_en), .clkout_o(clkout_o),
        .clkout_oe(clkout_oe), .run_enable(run_enable));
    pcdc_osc_model osc_i (.power_mode(power_mode), .osc_out_pin(osc));
    task print_verdict;
        if (fail_count == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input string nm, input [7:0] e, input [7:0] s);
        tests_run++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] %s exp %h got %h", nm, e, s);
        end
    endtask
    // Waitrequest and read data are taken at the rising edge that ends the wait
    task bus(input [3:0] a, input w, input [7:0] d);
        @(posedge clk);
        avs_address <= a; avs_write <= w; avs_read <= !w; avs_writedata <= {24'h0, d};
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata_w[7:0];
        avs_read <= 0; avs_write <= 0;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            print_verdict;
        end
    end
    initial begin
        rows = '{20'h0_85_85, 20'h0_70_40, 20'h4_f6_02, 20'h4_0d_09, 20'h8_ff_00};
        repeat (3) @(posedge clk);
        arst_n <= 1;
        bus(4'h0, 0, 0); chk("scc_rst", 8'h00, q);
        bus(4'h4, 0, 0); chk("pmc_rst", 8'h00, q);
        chk("mult_rst", 8'h00, 8'(mult_active));
        for (i = 0; i < 5; i++) begin
            bus(rows[i][19:16], 1, rows[i][15:8]);
            bus(rows[i][19:16], 0, 0); chk("readback", rows[i][7:0], q);
        end
        for (i = 0; i < 6; i++) begin
            bus(4'h0, 1, 8'h08 | i); bus(4'h4, 1, i % 3);
            repeat (70) @(posedge clk);
            chk("div", i, 8'(div_active));
            chk("mult_now", i % 3, 8'(mult_active));
        end
        bus(4'h4, 1, 8'h00); bus(4'h0, 1, 8'h80);
        repeat (40) @(posedge clk);
        chk("out_dis", 8'h01, 8'(clkout_o));
        bus(4'h4, 1, 8'h02); repeat (40) @(posedge clk);
        chk("mult_wait", 8'h00, 8'(mult_active));
        power_mode <= 3'h3; repeat (10) @(posedge clk);
        chk("mult_stby", 8'h02, 8'(mult_active));
        chk("out_stby", 8'h01, 8'(clkout_o));
        chk("osc_stby", 8'h01, 8'(osc));
        power_mode <= 3'h0; n = 0;
        repeat (100) @(posedge clk) n += (settling === 1'b1);
        chk("settle", 8'h01, 8'(n >= 31 && n <= 34));
        chk("run", 8'h01, 8'(run_enable));
        bus(4'h0, 1, 8'h01); power_mode <= 3'h2; n = 0; m = 0;
        repeat (40) @(posedge clk) begin
            n += (clkout_o === 1'b0);
            m += (sysclk_en === 1'b1);
        end
        chk("allstop", 8'h01, 8'(n > 0 && n < 40));
        chk("en_rate", 8'h01, 8'(m >= 19 && m <= 22));
        arst_n <= 0; @(posedge clk); arst_n <= 1;
        bus(4'h0, 0, 0); chk("scc_rst2", 8'h00, q);
        power_mode <= 3'h4; repeat (10) @(posedge clk);
        chk("hw_stby", 8'h00, 8'(clkout_oe));
        print_verdict;
    end
endmodule
